// file: rtl/arb_if.sv
// request and grant bundle between the port and its arbiter
`timescale 1ns/1ps
interface arb_if #(parameter int N = 2);
  logic [N-1:0] req;     // eligible site requests
  logic [N-1:0] grant;   // one-hot grant
  logic         advance; // grant is consumed this cycle
  modport arb  (input req, input advance, output grant);
  modport user (output req, output advance, input grant);
endinterface

// file: rtl/memory_master_port.sv
// memory master port: base conduit, site arbitration, bus master
//
// The implementer's own choices: round-robin site arbitration and an 8-entry read tag queue.
`timescale 1ns/1ps
`include "memport_defines.svh"
module memory_master_port #(
  // defaults give the plain shared port
  parameter int                    DWIDTH     = `MP_DWIDTH,
  parameter int                    AWIDTH     = `MP_AWIDTH,
  parameter int                    LATENCY    = `MP_LATENCY,
  parameter int                    MAXBURST   = `MP_MAXBURST,
  parameter int                    ASPACE     = `MP_ASPACE,
  parameter int                    ALIGN      = `MP_ALIGN,
  parameter bit                    WAITREQ_EN = `MP_WAITREQ_EN,
  parameter memport_pkg::rw_mode_t RW_MODE    = memport_pkg::MODE_RW,
  parameter int                    N          = `MP_N_SITES,
  parameter int                    ELEM_W     = 8 * `MP_ELEM_BYTES,
  parameter int                    IDX_W      = `MP_IDX_W,
  parameter int                    BC_W       = $clog2(MAXBURST) + 1
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                start,
  input  wire logic                finish,
  input  wire logic [`MP_BASE_W-1:0] base_addr,
  output logic                     busy,
  input  wire logic [N-1:0]        site_req,
  input  wire logic [N-1:0]        site_we,
  input  wire logic [IDX_W-1:0]    site_index [N],
  input  wire logic [ELEM_W-1:0]   site_wdata [N],
  output logic [N-1:0]             site_grant,
  output logic [N-1:0]             site_rvalid,
  output logic [ELEM_W-1:0]        site_rdata,
  output logic [AWIDTH-1:0]        bus_address,
  output logic                     bus_read,
  output logic                     bus_write,
  output logic [DWIDTH-1:0]        bus_writedata,
  output logic [DWIDTH/8-1:0]      bus_byteenable,
  output logic [BC_W-1:0]          bus_burstcount,
  input  wire logic                bus_waitrequest,
  input  wire logic [DWIDTH-1:0]   bus_readdata,
  input  wire logic                bus_readdatavalid
);
  import memport_pkg::*;

  // derived sizes; element lanes per bus word
  localparam int EB     = `MP_ELEM_BYTES;
  localparam int DB     = DWIDTH / 8;
  localparam int DB_LSB = $clog2(DB);
  localparam int E_LSB  = $clog2(EB);
  localparam int LANE_W = (DB_LSB > E_LSB) ? DB_LSB - E_LSB : 1;
  localparam int LANES  = DWIDTH / ELEM_W;
  localparam int LP     = (LATENCY > 0) ? LATENCY : 1;
  localparam int QD     = `MP_TAGQ_DEPTH;
  localparam int QW     = `MP_TAGQ_PTR_W;
  localparam int SW     = (N > 1) ? $clog2(N) : 1;
  localparam bit RD_EN  = (RW_MODE != MODE_WO);
  localparam bit WR_EN  = (RW_MODE != MODE_RO);

  // invocation state
  logic                  busy_ff;   // component running
  logic [`MP_BASE_W-1:0] base_ff;   // captured base pointer

  // held bus command
  logic                  cmd_valid_ff;
  logic                  cmd_we_ff;
  logic [AWIDTH-1:0]     cmd_addr_ff;
  logic [DWIDTH-1:0]     cmd_wdata_ff;
  logic [DB-1:0]         cmd_be_ff;
  logic [SW-1:0]         cmd_id_ff;    // issuing site
  logic [LANE_W-1:0]     cmd_lane_ff;  // element lane in word

  // outstanding read tags, returned in issue order
  logic [SW-1:0]         q_id_ff   [QD];
  logic [LANE_W-1:0]     q_lane_ff [QD];
  logic [QW-1:0]         q_wr_ff;
  logic [QW-1:0]         q_rd_ff;
  logic [LP-1:0]         lat_ff;       // fixed-latency read timer

  // returned data to the sites
  logic [N-1:0]          rvalid_ff;
  logic [ELEM_W-1:0]     rdata_ff;

  // combinational helpers
  logic                  eff_wait;     // slave stalls this cycle
  logic                  accepted;     // held command leaves
  logic                  can_load;     // command register free
  logic                  rd_accept;    // read taken by slave
  logic                  rd_arrive;    // read data on the bus
  logic                  q_full;
  logic [N-1:0]          elig;         // requests allowed now
  logic [SW-1:0]         sel;          // granted site index
  logic [63:0]           byte_addr;    // element byte address
  logic [63:0]           base_al;      // base with alignment
  logic [DB-1:0]         nxt_be;

  arb_if #(.N(N)) arb ();

  rr_arbiter #(.N(N)) u_arb (
    .clock   (clock),
    .sys_rst (sys_rst),
    .bus     (arb.arb)
  );

  // slave stall only counts when the pin is enabled
  assign eff_wait  = WAITREQ_EN && bus_waitrequest;
  assign accepted  = cmd_valid_ff && !eff_wait;
  assign can_load  = !cmd_valid_ff || !eff_wait;
  assign rd_accept = bus_read && !eff_wait;
  assign q_full    = (q_wr_ff - q_rd_ff) == QW'(QD);

  // variable latency trusts readdatavalid, fixed uses the timer
  assign rd_arrive = (LATENCY == 0) ? bus_readdatavalid
                                    : lat_ff[LP-1];

  // reads need a free tag slot; kinds the mode lacks are never served
  always_comb begin
    for (int i = 0; i < N; i++) begin
      elig[i] = site_req[i] && busy_ff &&
                (site_we[i] ? WR_EN : (RD_EN && !q_full));
    end
  end

  // all sites of this address space share one bus
  assign arb.req     = elig;
  assign arb.advance = can_load;
  assign site_grant  = arb.grant & {N{can_load}};

  // index of the single granted site
  always_comb begin
    sel = '0;
    for (int i = 0; i < N; i++) begin
      if (arb.grant[i]) begin
        sel = SW'(i);
      end
    end
  end

  // alignment lets low base bits be dropped; a misaligned base is
  // the caller's fault and is not repaired here
  assign base_al = base_ff & ~(64'(ALIGN) - 64'd1);

  // element steps scale the index by the element size
  assign byte_addr = base_al + 64'(site_index[sel]) * 64'(EB);

  // byte enables mark one element lane of the coalesced word
  assign nxt_be = DB'({EB{1'b1}}) << (byte_addr[LANE_W+E_LSB-1:E_LSB] * EB);

  // base pointer enters with start, never over the bus
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_ff <= `MP_BUSY_RST;
      base_ff <= '0;
    end else if (start && !busy_ff) begin
      busy_ff <= 1'b1;
      base_ff <= base_addr;
    end else if (finish) begin
      busy_ff <= 1'b0;
    end
  end
  assign busy = busy_ff;

  // command register: loaded on a grant, held while the slave stalls
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmd_valid_ff <= 1'b0;
    end else if (can_load) begin
      cmd_valid_ff <= |site_grant;
    end
  end

  // command fields change only when a new site is granted
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmd_we_ff    <= 1'b0;
      cmd_addr_ff  <= '0;
      cmd_wdata_ff <= '0;
      cmd_be_ff    <= '0;
      cmd_id_ff    <= '0;
      cmd_lane_ff  <= '0;
    end else if (|site_grant) begin
      cmd_we_ff    <= site_we[sel];
      // word address: element offset stripped, width cut to the bus
      cmd_addr_ff  <= AWIDTH'(byte_addr & ~(64'(DB) - 64'd1));
      cmd_wdata_ff <= {LANES{site_wdata[sel]}};
      cmd_be_ff    <= nxt_be;
      cmd_id_ff    <= sel;
      cmd_lane_ff  <= byte_addr[LANE_W+E_LSB-1:E_LSB];
    end
  end

  // bus drive straight from the held command
  assign bus_read       = cmd_valid_ff && !cmd_we_ff && RD_EN;
  assign bus_write      = cmd_valid_ff && cmd_we_ff && WR_EN;
  assign bus_address    = cmd_addr_ff;
  assign bus_writedata  = cmd_wdata_ff;
  assign bus_byteenable = cmd_be_ff;
  // every transfer is a single beat, which fixed latency demands
  assign bus_burstcount = BC_W'(1);

  // fixed-latency timer: one bit walks per accepted read
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lat_ff <= '0;
    end else begin
      lat_ff <= (lat_ff << 1) | LP'(rd_accept);
    end
  end

  // tag queue: slave returns in order, so first tag is the owner
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q_wr_ff <= '0;
    end else if (rd_accept) begin
      q_id_ff[q_wr_ff[QW-2:0]]   <= cmd_id_ff;
      q_lane_ff[q_wr_ff[QW-2:0]] <= cmd_lane_ff;
      q_wr_ff                    <= q_wr_ff + QW'(1);
    end
  end

  // pop on each returned word
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q_rd_ff <= '0;
    end else if (rd_arrive) begin
      q_rd_ff <= q_rd_ff + QW'(1);
    end
  end

  // read data routed to the site that asked for it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rvalid_ff <= '0;
      rdata_ff  <= '0;
    end else begin
      rvalid_ff <= '0;
      if (rd_arrive) begin
        rvalid_ff[q_id_ff[q_rd_ff[QW-2:0]]] <= 1'b1;
        rdata_ff <= bus_readdata[q_lane_ff[q_rd_ff[QW-2:0]] * ELEM_W
                                 +: ELEM_W];
      end
    end
  end
  assign site_rvalid = rvalid_ff;
  assign site_rdata  = rdata_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // legal configuration of the port
  property p_config;
    ASPACE > 0 && AWIDTH >= 1 && AWIDTH <= 64 &&
    MAXBURST >= 1 && MAXBURST <= 1024 &&
    (LATENCY == 0 || MAXBURST == 1) && DWIDTH >= 8 && DWIDTH <= 1024;
  endproperty
  a_config: assert property (p_config)
    else $error("illegal port configuration");

  // base taken at start while idle, then stable through the run
  property p_base_capture;
    start && !busy_ff |=> busy_ff && base_ff == $past(base_addr);
  endproperty
  a_base_capture: assert property (p_base_capture)
    else $error("base address not captured at start");

  property p_base_stable;
    busy_ff && $past(busy_ff) |-> $stable(base_ff);
  endproperty
  a_base_stable: assert property (p_base_stable)
    else $error("base address changed while busy");

  sequence s_stalled;
    (bus_read || bus_write) && eff_wait;
  endsequence
  // a stalled request stays asserted and holds address, write data and byte enables
  property p_hold;
    s_stalled |=> (bus_read || bus_write) && $stable(bus_address)
                  && $stable(bus_writedata) && $stable(bus_byteenable);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request dropped or changed under waitrequest");

  // single beat always
  property p_burst;
    bus_read || bus_write |-> bus_burstcount == BC_W'(1);
  endproperty
  a_burst: assert property (p_burst)
    else $error("burstcount not one");

  // disabled direction never appears on the bus
  property p_direction;
    !(bus_read && !RD_EN) && !(bus_write && !WR_EN);
  endproperty
  a_direction: assert property (p_direction)
    else $error("transfer in a disabled direction");

  // grant forms the word address of base plus scaled index
  property p_addr;
    |site_grant |=> bus_address ==
      AWIDTH'(($past(byte_addr)) & ~(64'(DB) - 64'd1));
  endproperty
  a_addr: assert property (p_addr)
    else $error("bus address not base plus scaled index");

  // latency one: accepted read is routed two edges later
  property p_lat_one;
    (LATENCY == 1) && rd_accept |=> rd_arrive ##1 (|site_rvalid);
  endproperty
  a_lat_one: assert property (p_lat_one)
    else $error("fixed latency read not returned on time");

  // returned data goes to exactly one site
  property p_route;
    $onehot0(site_rvalid) and ($rose(|site_rvalid) |-> $past(rd_arrive));
  endproperty
  a_route: assert property (p_route)
    else $error("read data routed to more than one site");
endmodule

// file: rtl/memport_defines.svh
// constants of the memory master port: widths, defaults and queue sizes
// Functional notes
// - base address captured with start/busy handshake
// - base address conduit always 64 bits
// - one bus per address space, sites arbitrated
// - address space id above zero, default 1
// - data width 8 to 1024, default 64
// - address width 1 to 64, default 64
// - latency sets read delay; 0 means variable
// - max burst 1 to 1024, sizes burstcount
// - fixed latency forces single-beat transfers
// - element-wide accesses, element-sized address steps
// - alignment drops low base address bits; data width sets elements per bus word
// - direction readwrite, readonly or writeonly
// - optional waitrequest holds request until released
// - default port: 64-bit data, address, latency 1
`ifndef MEMPORT_DEFINES_SVH
`define MEMPORT_DEFINES_SVH
`define MP_DWIDTH      64
`define MP_AWIDTH      64
`define MP_BASE_W      64
`define MP_LATENCY     1
`define MP_MAXBURST    1
`define MP_ASPACE      1
`define MP_ELEM_BYTES  4
`define MP_ALIGN       4
`define MP_N_SITES     2
`define MP_IDX_W       32
`define MP_TAGQ_DEPTH  8
`define MP_TAGQ_PTR_W  4
`define MP_WAITREQ_EN  0
`define MP_BUSY_RST    1'b0
`endif

// file: rtl/memport_pkg.sv
// types shared by the memory master port modules
package memport_pkg;
  // port direction of the master bus
  typedef enum logic [1:0] {
    MODE_RW,
    MODE_RO,
    MODE_WO
  } rw_mode_t;
endpackage

// file: rtl/rr_arbiter.sv
// round-robin arbiter over the load-store sites of one address space
`timescale 1ns/1ps
module rr_arbiter #(
  parameter int N = 2
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  arb_if.arb        bus
);
  import memport_pkg::*;

  logic [$clog2(N)-1:0] last_ff;  // most recent winner
  logic [$clog2(N)-1:0] win_idx;  // current winner index
  logic                 found;    // a winner was picked
  int                   idx;      // candidate being examined

  // search starts one past the last winner so no site starves
  always_comb begin
    bus.grant = '0;
    found     = 1'b0;
    win_idx   = '0;
    idx       = 0;
    for (int k = 1; k <= N; k++) begin
      idx = (int'(last_ff) + k) % N;
      if (!found && bus.req[idx]) begin
        bus.grant[idx] = 1'b1;
        win_idx        = idx[$clog2(N)-1:0];
        found          = 1'b1;
      end
    end
  end

  // priority pointer moves only when a grant is really used
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_ff <= '0;
    end else if (bus.advance && found) begin
      last_ff <= win_idx;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // one winner at most, and only among requesters
  property p_grant_legal;
    (bus.grant & ~bus.req) == '0 && $onehot0(bus.grant);
  endproperty
  a_grant_legal: assert property (p_grant_legal)
    else $error("grant not one-hot or to an idle site");

  sequence s_win0_used;
    bus.grant[0] && bus.advance && bus.req[N-1];
  endsequence
  // site 0 served while the last site waits: the last site goes next
  property p_rr_turn;
    s_win0_used ##1 bus.req[N-1] |-> bus.grant[N-1];
  endproperty
  a_rr_turn: assert property (p_rr_turn)
    else $error("waiting site skipped by round robin");
endmodule

// file: verif/mem_model.sv
// external memory model answering the master port with fixed read latency
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clock,
  input  wire logic [63:0] bus_address,
  input  wire logic        bus_read,
  input  wire logic        bus_write,
  input  wire logic [63:0] bus_writedata,
  input  wire logic [7:0]  bus_byteenable,
  output logic             bus_waitrequest,
  output logic [63:0]      bus_readdata,
  output logic             bus_readdatavalid
);
  logic [63:0] mem [256]; // private storage, one per address space
  logic [7:0]  word;      // word index taken from the byte address

  assign word = bus_address[10:3];
  // this memory never stalls, so waitrequest stays low
  assign bus_waitrequest = 1'b0;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 64'h0;
    end
    bus_readdata = 64'h0;
    bus_readdatavalid = 1'b0;
  end

  // data one cycle after the taking cycle, else garbage
  always @(posedge clock) begin
    if (bus_write) begin
      // only the lanes marked by byteenable are stored
      for (int b = 0; b < 8; b++) begin
        if (bus_byteenable[b]) begin
          mem[word][8*b +: 8] <= bus_writedata[8*b +: 8];
        end
      end
    end
    if (bus_read) begin
      bus_readdata <= mem[word];
      bus_readdatavalid <= 1'b1;
    end else begin
      // released bus shows the inverse so stale data never passes
      bus_readdata <= ~bus_readdata;
      bus_readdatavalid <= 1'b0;
    end
  end
endmodule

// file: verif/test_memory_master_port.sv
// self-checking bench of the memory master port with its memory model
`timescale 1ns/1ps
module test_memory_master_port;
  import memport_pkg::*;
  logic        clock;              // 25 MHz clock
  logic        sys_rst;            // synchronous reset
  logic        start;              // invocation start pulse
  logic        finish;             // invocation end pulse
  logic [63:0] base_addr;          // base pointer conduit
  logic        busy;               // invocation running
  logic [1:0]  site_req;           // site requests
  logic [1:0]  site_we;            // site write selects
  logic [31:0] site_index [2];     // element indices
  logic [31:0] site_wdata [2];     // write elements
  logic [1:0]  site_grant;         // grants
  logic [1:0]  site_rvalid;        // read returns
  logic [31:0] site_rdata;         // returned element
  logic [63:0] bus_address;        // master address
  logic        bus_read;           // read command
  logic        bus_write;          // write command
  logic [63:0] bus_writedata;      // write word
  logic [7:0]  bus_byteenable;     // lane select
  logic [0:0]  bus_burstcount;     // burst count
  logic        bus_waitrequest;    // slave stall
  logic [63:0] bus_readdata;       // read word
  logic        bus_readdatavalid;  // read word valid
  logic [63:0] base_r;             // base the port should be using
  int          n_fail;             // mismatches
  int          num_checks;         // comparisons
  int          cyc;                // cycles since time zero
  // ordinary cases: site, write, index, data (read rows expect data)
  typedef struct { int s; logic we; logic [31:0] idx; logic [31:0] d; } row_t;
  row_t rows [6] = '{'{0, 1'b1, 32'h0, 32'hA1A1_0001},
                     '{1, 1'b1, 32'h1, 32'hB2B2_0002},
                     '{0, 1'b0, 32'h1, 32'hB2B2_0002},
                     '{1, 1'b0, 32'h0, 32'hA1A1_0001},
                     '{0, 1'b1, 32'h5, 32'hC3C3_0005},
                     '{1, 1'b0, 32'h5, 32'hC3C3_0005}};

  memory_master_port memory_master_port_i (
    .clock(clock), .sys_rst(sys_rst), .start(start), .finish(finish),
    .base_addr(base_addr), .busy(busy), .site_req(site_req),
    .site_we(site_we), .site_index(site_index), .site_wdata(site_wdata),
    .site_grant(site_grant), .site_rvalid(site_rvalid),
    .site_rdata(site_rdata), .bus_address(bus_address),
    .bus_read(bus_read), .bus_write(bus_write),
    .bus_writedata(bus_writedata), .bus_byteenable(bus_byteenable),
    .bus_burstcount(bus_burstcount), .bus_waitrequest(bus_waitrequest),
    .bus_readdata(bus_readdata), .bus_readdatavalid(bus_readdatavalid));

  mem_model mem_model_i (
    .clock(clock), .bus_address(bus_address), .bus_read(bus_read),
    .bus_write(bus_write), .bus_writedata(bus_writedata),
    .bus_byteenable(bus_byteenable), .bus_waitrequest(bus_waitrequest),
    .bus_readdata(bus_readdata), .bus_readdatavalid(bus_readdatavalid));

  // clock generator, 40 ns period
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // one compare for every kind of value
  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // closing report, the single end of the run
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs under a hundred cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end

  // one access of a site: wait grant, check command, then read return;
  // the request rises just after an edge, so the grant is seen at the
  // falling edge before the rising edge that takes it, and never twice
  task automatic access(input int s, input logic we, input logic [31:0] idx,
                        input logic [31:0] d);
    int          n;
    logic [63:0] ba;
    @(posedge clock);
    site_req[s] <= 1'b1;
    site_we[s] <= we;
    site_index[s] <= idx;
    site_wdata[s] <= d;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (site_grant[s] !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("grant", 64'h1, 64'(site_grant[s]));
    end
    @(posedge clock);
    site_req[s] <= 1'b0;
    @(negedge clock);
    ba = (base_r & ~64'h3) + 64'(4 * idx);
    chk("read cmd", 64'(!we), 64'(bus_read));
    chk("write cmd", 64'(we), 64'(bus_write));
    chk("address", ba & ~64'h7, bus_address);
    chk("byteenable", ba[2] ? 64'hF0 : 64'h0F,
        64'(bus_byteenable));
    chk("burstcount", 64'h1, 64'(bus_burstcount));
    if (we) begin
      chk("writedata", {d, d}, bus_writedata);
    end else begin
      n = 1;
      while (site_rvalid[s] !== 1'b1 && n < 20) begin
        @(negedge clock);
        n++;
      end
      chk("return delay", 64'h3, 64'(n));
      chk("read data", 64'(d), 64'(site_rdata));
    end
  endtask

  // one cycle pulse on start or finish
  task automatic pulse(input logic st, input logic [63:0] b);
    @(posedge clock);
    start <= st;
    finish <= !st;
    base_addr <= b;
    @(posedge clock);
    start <= 1'b0;
    finish <= 1'b0;
  endtask

  initial begin
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    sys_rst = 1'b1;
    start = 1'b0;
    finish = 1'b0;
    base_addr = 64'h0;
    site_req = 2'b00;
    site_we = 2'b00;
    site_index = '{32'h0, 32'h0};
    site_wdata = '{32'h0, 32'h0};
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk("reset busy", 64'h0, 64'(busy));
    chk("reset cmd", 64'h0, 64'({bus_read, bus_write}));
    chk("reset rvalid", 64'h0, 64'(site_rvalid));
    // requests while idle are never granted
    @(posedge clock);
    site_req[0] <= 1'b1;
    repeat (4) begin
      @(negedge clock);
      chk("idle grant", 64'h0, 64'(site_grant));
    end
    @(posedge clock);
    site_req[0] <= 1'b0;
    // invocation one: base taken with start
    base_r = 64'h0000_0000_0000_1004; // aligned to 4
    pulse(1'b1, base_r);
    @(negedge clock);
    chk("busy", 64'h1, 64'(busy));
    pulse(1'b1, 64'h0000_0000_0000_2000); // start while busy is ignored
    foreach (rows[i]) begin
      access(rows[i].s, rows[i].we, rows[i].idx, rows[i].d);
    end
    // both sites at once: each served, data back to its issuer
    fork
      access(0, 1'b0, 32'h0, 32'hA1A1_0001);
      access(1, 1'b0, 32'h5, 32'hC3C3_0005);
    join
    pulse(1'b0, 64'h0);
    @(negedge clock);
    chk("busy after finish", 64'h0, 64'(busy));
    // invocation two: upper half of the 64-bit base kept
    base_r = 64'h1234_0000_0000_0100; // aligned
    pulse(1'b1, base_r);
    access(1, 1'b1, 32'h3, 32'h5A5A_0003);
    access(0, 1'b0, 32'h3, 32'h5A5A_0003);
    // reset in mid-run drops the invocation
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk("mid-run reset busy", 64'h0, 64'(busy));
    chk("mid-run reset cmd", 64'h0, 64'({bus_read, bus_write}));
    pulse(1'b0, 64'h0);
    repeat (2) @(posedge clock);
    print_verdict();
  end
endmodule
